/* File: common/cfep_pkg.sv */
// ------------------------------
// Shared constants of the core
// ------------------------------
package cfep_pkg;

	// Clocking: one instruction cycle is four clock phases
	localparam int CFEP_PHASES = 4;
	localparam int CFEP_CLK_PERIOD_NS = 100;
	localparam int CFEP_CYCLE_NS = CFEP_PHASES * CFEP_CLK_PERIOD_NS;
	localparam logic [3:0] CFEP_PH_RST = 4'h1;

	// Widths
	localparam int CFEP_IW = 12;
	localparam int CFEP_DW = 8;
	localparam int CFEP_IPW = 11;
	localparam int CFEP_PAW = 10;
	localparam int CFEP_DAW = 6;

	// Program memory map
	localparam logic [10:0] CFEP_RESET_VEC = 11'h000;
	localparam logic [10:0] CFEP_CAL_WORD = 11'h3FF;
	localparam logic [10:0] CFEP_DFLASH_LO = 11'h400;
	localparam logic [10:0] CFEP_DFLASH_HI = 11'h43F;

	// Register file split
	localparam int CFEP_NUM_SPECIAL = 10;
	localparam int CFEP_NUM_GENERAL = 41;
	localparam logic [3:0] CFEP_A_INDIRECT = 4'h0;
	localparam logic [3:0] CFEP_A_IP_LOW = 4'h2;
	localparam logic [3:0] CFEP_A_STATUS = 4'h3;
	localparam logic [3:0] CFEP_A_FSP = 4'h4;

	// Status fields and reset values
	localparam int CFEP_ST_PAGE = 5;
	localparam logic [7:0] CFEP_ST_RST = 8'h18;
	localparam logic [7:0] CFEP_FSP_RST = 8'hC0;

	// Opcode fields used by the decoder
	localparam logic [1:0] CFEP_G_BYTE = 2'h0;
	localparam logic [1:0] CFEP_G_BIT = 2'h1;
	localparam logic [1:0] CFEP_G_BRANCH = 2'h2;
	localparam logic [1:0] CFEP_G_LIT = 2'h3;
	localparam logic [3:0] CFEP_OP_SUB = 4'h2;
	localparam logic [3:0] CFEP_OP_ADD = 4'h7;
	localparam logic [3:0] CFEP_OP_DECSKIP = 4'hB;
	localparam logic [3:0] CFEP_OP_INCSKIP = 4'hF;
	localparam logic [3:0] CFEP_OP_RETURN = 4'h8;
	localparam logic [3:0] CFEP_OP_CALL = 4'h9;

	// Host register indices and reset
	localparam logic [2:0] CFEP_H_CTRL = 3'h0;
	localparam logic [2:0] CFEP_H_ACC = 3'h1;
	localparam logic [2:0] CFEP_H_STATUS = 3'h2;
	localparam logic [2:0] CFEP_H_IPL = 3'h3;
	localparam logic [2:0] CFEP_H_IPH = 3'h4;
	localparam logic CFEP_RUN_RST = 1'b1;

	typedef enum logic [3:0] {
		OP_PASSA, OP_PASSW, OP_CLR, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR,
		OP_COM, OP_INC, OP_DEC, OP_RL, OP_RR, OP_SWAP, OP_BC, OP_BS
	} cfep_alu_op_e;

endpackage

/* File: hdl/cfep_alu.sv */
`timescale 1ns/10ps
// ------------------------------
// Eight-bit arithmetic unit
// ------------------------------
module cfep_alu
	import cfep_pkg::*;
(
	input wire cfep_alu_op_e op, // Operation
	input wire logic [7:0] a, // File or literal operand
	input wire logic [7:0] w, // Accumulator
	input wire logic cin, // Carry in for rotates
	input wire logic [2:0] bsel, // Bit index
	output logic [7:0] res, // Result
	output logic c_out, // Carry out
	output logic nc_out, // Nibble carry out
	output logic z_out // Result is zero
);
	// Subtract as a + ~w + 1, so carries come out as inverted borrows
	wire sub = (op == OP_SUB);
	wire [7:0] b = sub ? ~w : w;
	wire [8:0] sum = {1'b0, a} + {1'b0, b} + {8'h00, sub};
	wire [4:0] nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, sub};
	wire [7:0] bmask = 8'h01 << bsel;

	always_comb begin
		res = a;
		unique case (op)
			OP_PASSA: res = a;
			OP_PASSW: res = w;
			OP_CLR: res = 8'h00;
			OP_ADD, OP_SUB: res = sum[7:0];
			OP_AND: res = a & w;
			OP_IOR: res = a | w;
			OP_XOR: res = a ^ w;
			OP_COM: res = ~a;
			OP_INC: res = a + 8'h01;
			OP_DEC: res = a - 8'h01;
			OP_RL: res = {a[6:0], cin};
			OP_RR: res = {cin, a[7:1]};
			OP_SWAP: res = {a[3:0], a[7:4]};
			OP_BC: res = a & ~bmask;
			OP_BS: res = a | bmask;
		endcase
	end

	assign c_out = (op == OP_RL) ? a[7] : ((op == OP_RR) ? a[0] : sum[8]);
	assign nc_out = nib[4];
	assign z_out = (res == 8'h00);
endmodule // cfep_alu

/* File: hdl/cfep_core.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - Program and data memory use separate ports, usable in one cycle.
// - Instruction words are 12 bits, one whole word per fetch.
// - The next word is fetched while the current one executes.
// - A plain instruction completes in one instruction cycle.
// - Clock divided into four phases forming one instruction cycle.
// - Pointer increments in phase one; word captured in phase four.
// - Latch loads in phase one; execution over phases two to four.
// - Operand read in phase two, result written in phase four.
// - Pointer-changing instructions take two cycles; prefetched word dropped.
// - Eight-bit unit doing add, subtract, shifts and logic, two's complement.
// - Accumulator pairs with file or literal; single ops use either.
// - Accumulator is eight bits and has no data memory address.
// - Carry, nibble carry and zero flags update per instruction.
// - In subtraction carry and nibble carry are inverted borrows.
// - Pointer is 11 bits; fetches wrap into the 1K-word space.
// - After reset the first fetch is from address 0000h.
// - Data flash occupies program addresses 400h to 43Fh.
// - Jumps and calls take their page from the status page select bit.
// - Data banks are selected through the file select pointer.
// - Special registers, pointer low byte included, sit in data memory.
// - Register file holds 10 special and 41 general purpose registers.
// - Status as destination of a flag-setting op keeps the flag results.
// - General registers reachable directly or through the file select pointer.
module cfep_core
	import cfep_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic rst_n, // Asynchronous reset, active low
	output logic [CFEP_PAW-1:0] prog_addr, // Program memory word address
	input wire logic [CFEP_IW-1:0] prog_data, // Program memory word
	output logic [CFEP_DAW-1:0] data_addr, // Data memory address
	output logic data_rd, // Data read strobe, phase two
	output logic data_wr, // Data write strobe, phase four
	output logic [CFEP_DW-1:0] data_wdata, // Data write value
	input wire logic [CFEP_DW-1:0] data_rdata, // Read value, cycle after strobe
	output logic [3:0] phase, // One-hot phase, bit 0 is phase one
	input wire logic [2:0] host_addr, // Host register index
	input wire logic [7:0] host_wdata, // Host write data
	input wire logic host_wr, // Host write strobe
	input wire logic host_rd, // Host read strobe
	output logic [7:0] host_rdata // Host read data, one cycle later
);
	// ------------------------------
	// State
	// ------------------------------
	logic [3:0] ph_q;
	logic run_q;
	logic [10:0] ip_q;
	logic [10:0] tgt_q;
	logic tgtv_q;
	logic [CFEP_PAW-1:0] pa_q;
	logic [11:0] fetch_q;
	logic [11:0] ilat_q;
	logic ok_q;
	logic fl_q;
	logic [7:0] w_q;
	logic [7:0] st_q;
	logic [5:0] fsp_q;
	logic [10:0] stk0_q;
	logic [10:0] stk1_q;
	logic [CFEP_DAW-1:0] da_q;
	logic drd_q;
	logic dwr_q;
	logic [7:0] dwd_q;
	logic [7:0] hrd_q;

	// ------------------------------
	// Phase generator
	// ------------------------------
	// Halting parks the ring in phase four so nothing repeats
	wire cyc_end = ph_q[3] & run_q;
	wire ph1_end = ph_q[0];
	wire ph3_end = ph_q[2];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q <= CFEP_PH_RST;
		end else if (!ph_q[3] || run_q) begin
			ph_q <= {ph_q[2:0], ph_q[3]};
		end
	end

	// ------------------------------
	// Decode
	// ------------------------------
	wire [1:0] grp = ilat_q[11:10];
	wire [3:0] opc = ilat_q[9:6];
	wire dbit = ilat_q[5];
	wire [4:0] fld = ilat_q[4:0];
	wire g_byte = (grp == CFEP_G_BYTE);
	wire g_bit = (grp == CFEP_G_BIT);
	wire g_lit = (grp == CFEP_G_LIT);
	wire is_goto = (grp == CFEP_G_BRANCH) && ilat_q[9];
	wire is_call = (ilat_q[11:8] == CFEP_OP_CALL);
	wire is_ret = (ilat_q[11:8] == CFEP_OP_RETURN);
	wire add_sub = g_byte && (opc == CFEP_OP_ADD || opc == CFEP_OP_SUB);
	wire rot = g_byte && (opc[3:1] == 3'h6);
	wire fsz = g_byte && (opc == CFEP_OP_DECSKIP || opc == CFEP_OP_INCSKIP);

	// Map an instruction word onto a unit operation
	function automatic cfep_alu_op_e alu_sel(input logic [11:0] i);
		cfep_alu_op_e o;
		o = OP_PASSA;
		unique case (i[11:10])
			CFEP_G_BYTE: begin
				unique case (i[9:6])
					4'h0: o = OP_PASSW;
					4'h1: o = OP_CLR;
					4'h2: o = OP_SUB;
					4'h3, 4'hB: o = OP_DEC;
					4'h4: o = OP_IOR;
					4'h5: o = OP_AND;
					4'h6: o = OP_XOR;
					4'h7: o = OP_ADD;
					4'h8: o = OP_PASSA;
					4'h9: o = OP_COM;
					4'hA, 4'hF: o = OP_INC;
					4'hC: o = OP_RR;
					4'hD: o = OP_RL;
					4'hE: o = OP_SWAP;
				endcase
			end
			CFEP_G_BIT: begin
				o = (i[9:8] == 2'h0) ? OP_BC : ((i[9:8] == 2'h1) ? OP_BS : OP_PASSA);
			end
			CFEP_G_LIT: begin
				unique case (i[9:8])
					2'h0: o = OP_PASSA;
					2'h1: o = OP_IOR;
					2'h2: o = OP_AND;
					2'h3: o = OP_XOR;
				endcase
			end
			CFEP_G_BRANCH: o = OP_PASSA;
		endcase
		return o;
	endfunction

	wire z_aff = add_sub || (g_lit && ilat_q[9:8] != 2'h0) ||
		(g_byte && (opc inside {4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA}));
	wire c_aff = add_sub || rot;
	wire nc_aff = add_sub;

	wire wr_w = (g_byte && !dbit && opc != 4'h0) || g_lit || is_ret;
	wire wr_f = (g_byte && dbit) || (g_bit && !ilat_q[9]);
	wire need_rd = (g_byte && opc[3:1] != 3'h0) || g_bit;

	// ------------------------------
	// Data addressing
	// ------------------------------
	// bank bit from pointer
	wire [5:0] raw_ea = (fld == 5'h00) ? fsp_q : {fsp_q[5], fld};
	// Low half of every bank mirrors the special registers
	wire [5:0] ea = raw_ea[4] ? raw_ea : {1'b0, raw_ea[4:0]};
	// other specials and general registers go outside
	wire in_low = !ea[4];
	wire hit_ind = in_low && (ea[3:0] == CFEP_A_INDIRECT);
	wire hit_ipl = in_low && (ea[3:0] == CFEP_A_IP_LOW);
	wire hit_st = in_low && (ea[3:0] == CFEP_A_STATUS);
	wire hit_fsp = in_low && (ea[3:0] == CFEP_A_FSP);
	wire hit_int = hit_ind || hit_ipl || hit_st || hit_fsp;
	wire [7:0] int_val = hit_ipl ? ip_q[7:0] : (hit_st ? st_q :
		(hit_fsp ? (CFEP_FSP_RST | {2'h0, fsp_q}) : 8'h00));

	wire [7:0] opnd = (g_lit || is_ret) ? ilat_q[7:0] : (hit_int ? int_val : data_rdata);

	// ------------------------------
	// Arithmetic unit
	// ------------------------------
	wire [7:0] alu_res;
	wire alu_c;
	wire alu_nc;
	wire alu_z;
	wire cfep_alu_op_e alu_op = alu_sel(ilat_q);

	cfep_alu u_alu (
		.op(alu_op),
		.a(opnd),
		.w(w_q),
		.cin(st_q[0]),
		.bsel(ilat_q[7:5]),
		.res(alu_res),
		.c_out(alu_c),
		.nc_out(alu_nc),
		.z_out(alu_z)
	);

	// ------------------------------
	// Branch and skip
	// ------------------------------
	wire bit_tst = opnd[ilat_q[7:5]];
	wire skip = (fsz && alu_z) || (g_bit && ilat_q[9] && (bit_tst == ilat_q[8]));
	wire ipl_w = wr_f && hit_ipl;
	wire jmp = ok_q && (is_goto || is_call || is_ret || ipl_w);
	wire take = jmp || (ok_q && skip);
	wire pg = st_q[CFEP_ST_PAGE];

	wire [10:0] tgt_d = is_ret ? stk0_q :
		(is_goto ? {1'b0, pg, ilat_q[8:0]} : {1'b0, pg, 1'b0, ilat_q[7:0]});

	// ------------------------------
	// Fetch stage
	// ------------------------------
	// Pending target wins over the plain step
	wire [10:0] ip_d = tgtv_q ? tgt_q : ip_q + 11'h001;

	// wrap keeps fetch out of data flash
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ip_q <= CFEP_RESET_VEC;
			pa_q <= 10'h000;
			tgt_q <= CFEP_RESET_VEC;
			tgtv_q <= 1'b1;
		end else if (cyc_end) begin
			ip_q <= ip_d;
			pa_q <= ip_d[CFEP_PAW-1:0];
			tgtv_q <= 1'b0;
		end else if (ph3_end && jmp) begin
			tgt_q <= (is_call || is_goto || is_ret) ? tgt_d :
				{1'b0, pg, 1'b0, alu_res};
			tgtv_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_q <= 12'h000;
			ilat_q <= 12'h000;
			ok_q <= 1'b0;
			fl_q <= 1'b1;
		end else if (cyc_end) begin
			ilat_q <= fetch_q;
			ok_q <= !fl_q;
			fl_q <= 1'b0;
		end else if (ph3_end) begin
			fetch_q <= prog_data;
			fl_q <= fl_q || take;
		end
	end

	// ------------------------------
	// Core register write back
	// ------------------------------
	// only a live instruction commits
	wire commit = ph3_end && ok_q;
	wire flag_op = z_aff || c_aff;

	wire [7:0] st_w = {alu_res[7], 1'b0, alu_res[5], st_q[4:3],
		flag_op ? st_q[2:0] : alu_res[2:0]};
	wire [7:0] st_b = (wr_f && hit_st) ? st_w : st_q;
	wire [7:0] st_d = {st_b[7:3], z_aff ? alu_z : st_b[2],
		nc_aff ? alu_nc : st_b[1], c_aff ? alu_c : st_b[0]};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			w_q <= 8'h00;
			st_q <= CFEP_ST_RST;
			fsp_q <= 6'h00;
		end else if (commit) begin
			w_q <= wr_w ? alu_res : w_q;
			st_q <= st_d;
			fsp_q <= (wr_f && hit_fsp) ? alu_res[5:0] : fsp_q;
		end
	end

	// Two-level return stack; a third call drops the oldest entry
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stk0_q <= 11'h000;
			stk1_q <= 11'h000;
		end else if (commit && is_call) begin
			stk0_q <= ip_q;
			stk1_q <= stk0_q;
		end else if (commit && is_ret) begin
			stk0_q <= stk1_q;
		end
	end

	// ------------------------------
	// External data port
	// ------------------------------
	// own data port beside fetch
	// read in two, write in four
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			da_q <= 6'h00;
			drd_q <= 1'b0;
			dwr_q <= 1'b0;
			dwd_q <= 8'h00;
		end else begin
			da_q <= ph1_end ? ea : da_q;
			drd_q <= ph1_end && ok_q && need_rd && !hit_int;
			dwr_q <= commit && wr_f && !hit_int;
			dwd_q <= commit ? alu_res : dwd_q;
		end
	end

	// ------------------------------
	// Host register port
	// ------------------------------
	wire [7:0] hsel = (host_addr == CFEP_H_CTRL) ? {7'h00, run_q} :
		(host_addr == CFEP_H_ACC) ? w_q :
		(host_addr == CFEP_H_STATUS) ? st_q :
		(host_addr == CFEP_H_IPL) ? ip_q[7:0] :
		(host_addr == CFEP_H_IPH) ? {5'h00, ip_q[10:8]} : 8'h00;

	// Run bit gates the phase ring; read data lives for one cycle only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= CFEP_RUN_RST;
			hrd_q <= 8'h00;
		end else begin
			run_q <= (host_wr && host_addr == CFEP_H_CTRL) ? host_wdata[0] : run_q;
			hrd_q <= host_rd ? hsel : 8'h00;
		end
	end

	// ------------------------------
	// Outputs
	// ------------------------------
	assign prog_addr = pa_q;
	assign data_addr = da_q;
	assign data_rd = drd_q;
	assign data_wr = dwr_q;
	assign data_wdata = dwd_q;
	assign phase = ph_q;
	assign host_rdata = hrd_q;
endmodule // cfep_core

/* File: verif/cfep_core_sva.sv */
`timescale 1ns/10ps
// ----------------------------
// Port checker of the core
// ----------------------------
module cfep_core_sva
	import cfep_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic rst_n, // Reset, active low
	input wire logic [CFEP_PAW-1:0] prog_addr, // Fetch address
	input wire logic [CFEP_DAW-1:0] data_addr, // Data address
	input wire logic data_rd, // Data read strobe
	input wire logic data_wr, // Data write strobe
	input wire logic [3:0] phase // One-hot phase
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Core-internal places must never show up on the external data port
	logic int_hit;
	assign int_hit = !data_addr[4] && (data_addr[3:0] inside {4'h0, 4'h2, 4'h3, 4'h4});

	a_ring_start: assert property (phase == 4'h1 |=> phase == 4'h2)
		else $error("phase one not followed by phase two");
	a_ring_mid: assert property (phase == 4'h2 |=> phase == 4'h4 ##1 phase == 4'h8)
		else $error("phase two not followed by three and four");
	a_ring_wrap: assert property (phase == 4'h8 |=> phase inside {4'h1, 4'h8})
		else $error("phase four left to a wrong phase");
	a_fetch_edge: assert property ($changed(prog_addr) |-> phase == 4'h1)
		else $error("fetch address moved outside phase one");
	a_fetch_hold: assert property ($changed(prog_addr) |=> $stable(prog_addr) [*3])
		else $error("fetch address held less than one instruction cycle");
	a_read_phase: assert property (data_rd |-> phase == 4'h2 && !data_wr)
		else $error("data read outside phase two");
	a_write_phase: assert property (data_wr |-> phase == 4'h8)
		else $error("data write outside phase four");
	a_addr_hold: assert property (data_rd |=> $stable(data_addr) [*2])
		else $error("data address moved during the access");
	a_internal_regs: assert property ((data_rd || data_wr) |-> !int_hit)
		else $error("internal register access reached the data port");

	c_read_write: cover property (data_rd ##2 data_wr);
	c_parked: cover property (phase == 4'h8 [*3]);
	c_wrap: cover property ($changed(prog_addr) && prog_addr == 10'h000);
endmodule // cfep_core_sva

bind cfep_core cfep_core_sva cfep_core_sva_i (
	.clk(clk),
	.rst_n(rst_n),
	.prog_addr(prog_addr),
	.data_addr(data_addr),
	.data_rd(data_rd),
	.data_wr(data_wr),
	.phase(phase)
);

/* File: verif/cfep_mem_model.sv */
`timescale 1ns/10ps
// ----------------------------
// Program array and data file
// ----------------------------
module cfep_mem_model
	import cfep_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic [CFEP_PAW-1:0] prog_addr, // Fetch address
	output logic [CFEP_IW-1:0] prog_data, // Fetched word
	input wire logic [CFEP_DAW-1:0] data_addr, // Data address
	input wire logic data_rd, // Read strobe
	input wire logic data_wr, // Write strobe
	input wire logic [CFEP_DW-1:0] data_wdata, // Write value
	output logic [CFEP_DW-1:0] data_rdata // Read value
);
	// calibration word kept
	// The array is read-only here, so the top word is never overwritten
	logic [CFEP_IW-1:0] rom [0:1023];
	logic [CFEP_DW-1:0] ram [0:63];

	assign prog_data = rom[prog_addr];

	// Test program: arithmetic, flushed jump slot, paging, call, indirect store, skip
	initial begin
		for (int i = 0; i < 1024; i++) begin
			rom[i] = 12'h000;
		end
		for (int i = 0; i < 64; i++) begin
			ram[i] = 8'h00;
		end
		rom[0] = 12'hC05;
		rom[1] = 12'h030;
		rom[2] = 12'h1F0;
		rom[3] = 12'h090;
		rom[4] = 12'hA10;
		rom[5] = 12'hCEE;
		rom[16] = 12'h031;
		rom[17] = 12'h5A3;
		rom[18] = 12'hBF0;
		// Page one: call and return, indirect store, skipped word, cleared status
		rom[10'h3F0] = 12'h920;
		rom[10'h220] = 12'h842;
		rom[10'h3F1] = 12'h032;
		rom[10'h3F2] = 12'hC13;
		rom[10'h3F3] = 12'h024;
		rom[10'h3F4] = 12'hC05;
		rom[10'h3F5] = 12'h020;
		rom[10'h3F6] = 12'h7A3;
		rom[10'h3F7] = 12'hCEE;
		rom[10'h3F8] = 12'h034;
		rom[10'h3F9] = 12'h063;
		data_rdata = 8'h00;
	end

	// Read value stands one cycle only; it toggles otherwise so stale data cannot pass
	always @(posedge clk) begin
		if (data_wr) begin
			ram[data_addr] <= data_wdata;
		end
		if (data_rd) begin
			data_rdata <= ram[data_addr];
		end else begin
			data_rdata <= ~data_rdata;
		end
	end
endmodule // cfep_mem_model

/* File: verif/cfep_core_tb_top.sv */
`timescale 1ns/10ps
module cfep_core_tb_top
	import cfep_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n;
	logic [2:0] host_addr;
	logic [7:0] host_wdata;
	logic host_wr;
	logic host_rd;
	logic [7:0] host_rdata;
	logic [CFEP_PAW-1:0] prog_addr;
	logic [CFEP_IW-1:0] prog_data;
	logic [CFEP_DAW-1:0] data_addr;
	logic data_rd;
	logic data_wr;
	logic [CFEP_DW-1:0] data_wdata;
	logic [CFEP_DW-1:0] data_rdata;
	logic [3:0] phase;
	int n_fail = 0;
	int n_checks = 0;

	always #50 clk = ~clk;

	cfep_core cfep_core_i (.clk(clk), .rst_n(rst_n), .prog_addr(prog_addr),
		.prog_data(prog_data), .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr),
		.data_wdata(data_wdata), .data_rdata(data_rdata), .phase(phase),
		.host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr),
		.host_rd(host_rd), .host_rdata(host_rdata));
	cfep_mem_model cfep_mem_model_i (.clk(clk), .prog_addr(prog_addr), .prog_data(prog_data),
		.data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr),
		.data_wdata(data_wdata), .data_rdata(data_rdata));

	// ----------------------------
	// Shared tasks
	// ----------------------------
	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic host_write(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		host_addr <= a;
		host_wdata <= d;
		host_wr <= 1'b1;
		@(posedge clk);
		host_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic expect_reg(input string what, input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		host_addr <= a;
		host_rd <= 1'b1;
		@(posedge clk);
		host_rd <= 1'b0;
		#1;
		check(what, 12'(host_rdata), 12'(exp));
	endtask

	// Bounded wait for a fetch address
	task automatic wait_addr(input logic [9:0] v);
		int k;
		k = 0;
		while (prog_addr !== v && k < 500) begin
			@(posedge clk);
			#1;
			k++;
		end
		check("fetch address", 12'(prog_addr), 12'(v));
	endtask

	task automatic conclude;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ----------------------------
	// Main sequence
	// ----------------------------
	initial begin
		rst_n = 1'b0;
		host_addr = 3'h0;
		host_wdata = 8'h00;
		host_wr = 1'b0;
		host_rd = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check("reset phase", 12'(phase), 12'h001);
		check("reset fetch", 12'(prog_addr), 12'h000);
		@(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		check("first phase", 12'(phase), 12'h002);
		expect_reg("run bit", CFEP_H_CTRL, 8'h01);
		expect_reg("status reset", CFEP_H_STATUS, CFEP_ST_RST);
		// Page bit set before the jump decides where it lands
		wait_addr(10'h3FF);
		repeat (4) @(posedge clk);
		#1;
		check("wrapped fetch", 12'(prog_addr), 12'h000);
		check("sum in file", 12'(cfep_mem_model_i.ram[16]), 12'h00A);
		check("flushed slot", 12'(cfep_mem_model_i.ram[17]), 12'h005);
		check("call return", 12'(cfep_mem_model_i.ram[18]), 12'h042);
		check("indirect store", 12'(cfep_mem_model_i.ram[19]), 12'h005);
		check("skipped word", 12'(cfep_mem_model_i.ram[20]), 12'h005);
		// Reads race the rerun's addition, so they come first
		// Clearing status keeps both inverted borrows and sets zero
		expect_reg("status flags", CFEP_H_STATUS, 8'h1F);
		expect_reg("accumulator", CFEP_H_ACC, 8'h05);
		host_write(CFEP_H_ACC, 8'hFF);
		expect_reg("accumulator kept", CFEP_H_ACC, 8'h05);
		expect_reg("unmapped index", 3'h5, 8'h00);
		// Clearing the run bit parks the ring in phase four
		host_write(CFEP_H_CTRL, 8'h00);
		repeat (8) @(posedge clk);
		#1;
		check("parked phase", 12'(phase), 12'h008);
		host_write(CFEP_H_CTRL, 8'h01);
		// Second reset in mid-run
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		#1;
		check("mid reset phase", 12'(phase), 12'h001);
		check("mid reset fetch", 12'(prog_addr), 12'h000);
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		#1;
		check("second fetch", 12'(prog_addr), 12'h001);
		conclude();
	end

	// Watchdog well beyond the fewer than two hundred clocks the tests need
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		conclude();
	end
endmodule // cfep_core_tb_top
